// ===== hw/delay_timer.sv
// up-counter that flags when a programmed number of cycles has passed
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
	input wire logic clk,
	input wire logic rstSync,
	delay_timer_if.timer tmr
);
	logic [lpr_pkg::CNT_W-1:0] count; // cycles spent since restart
	logic [lpr_pkg::CNT_W-1:0] lastCount; // value at which the limit is met

	// limit of one or more; a zero limit behaves like one
	assign lastCount = (tmr.limit == '0) ? '0 : tmr.limit - lpr_pkg::CNT_ONE;
	assign tmr.done = (count >= lastCount);

	// count saturates so a stalled state never wraps and re-fires
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			count <= '0;
		end else if (tmr.restart) begin
			count <= '0;
		end else if (!tmr.done) begin
			count <= count + lpr_pkg::CNT_ONE;
		end
	end
endmodule : delay_timer
`default_nettype wire

// ===== hw/delay_timer_if.sv
// bundle between the sequencer and its delay timer
`timescale 1ns/1ps
`default_nettype none
interface delay_timer_if;
	logic restart; // start counting from zero
	logic [lpr_pkg::CNT_W-1:0] limit; // cycles to count
	logic done; // limit reached
	modport ctrl (output restart, output limit, input done);
	modport timer (input restart, input limit, output done);
endinterface : delay_timer_if
`default_nettype wire

// ===== hw/long_press_reset_generator.sv
// long-press reset generator: press timing, test mode and reset output drive
// Summary of operation
// - reset only after full continuous press delay
// - press delay fixed, 0.5 s to 10 s
// - short presses never cause reset
// - push-button input is active low
// - button-controlled variant releases on button release
// - fixed variant holds reset for pulse time
// - output polarity and drive type are build options
// - overvoltage starts 42 ms entry delay
// - entry expiry asserts reset as feedback
// - test mode press delay divided by 128
// - test mode persists until power cycle
// - power-up starts normal, output inactive
// - open-drain active-low output released at power-on
`timescale 1ns/1ps
`default_nettype none
module long_press_reset_generator #(
	parameter int unsigned PRESS_STEPS = lpr_pkg::PRESS_STEPS_DEF, // press delay in 0.5 s steps
	parameter logic [lpr_pkg::CNT_W-1:0] STEP_CYCLES = lpr_pkg::STEP_CYCLES, // cycles per step
	parameter logic [lpr_pkg::CNT_W-1:0] ENTRY_CYCLES = lpr_pkg::ENTRY_CYCLES, // test entry delay
	parameter logic [lpr_pkg::CNT_W-1:0] PULSE_CYCLES = lpr_pkg::PULSE_CYCLES, // fixed pulse time
	parameter bit FIXED_PULSE = 1'b0, // 1: fixed pulse, 0: button-controlled
	parameter bit ACTIVE_HIGH = 1'b0, // output polarity
	parameter bit OPEN_DRAIN = 1'b1 // output drive type
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic pushbutton_in_n,
	input wire logic overvoltage,
	output logic rstOut,
	output logic rstOeN,
	output logic testModeActive
);
	logic [1:0] rstPipe; // reset release pipeline
	logic rstSync; // reset copy used by all other logic
	logic ovMeta; // first overvoltage stage, read only by ovSync
	logic ovSync; // synchronised overvoltage flag
	lpr_pkg::state_e state; // current sequencer state
	lpr_pkg::state_e next_state; // state for the next edge
	logic testMode; // test-mode latch
	logic resetActive; // logical reset assertion, polarity free
	logic pressed; // button closure, decoded once
	logic next_testMode; // latch value for the next edge
	logic next_active; // next logical assertion
	logic next_level; // next pin level
	logic [lpr_pkg::CNT_W-1:0] pressCycles; // normal press delay in cycles
	logic [lpr_pkg::CNT_W-1:0] shortCycles; // test-mode press delay in cycles
	delay_timer_if tmrBus ();

	// build-time range guard for the press delay
	if (PRESS_STEPS < lpr_pkg::PRESS_STEPS_MIN || PRESS_STEPS > lpr_pkg::PRESS_STEPS_MAX) begin : g_badSteps
		$error("press delay steps out of range");
	end

	// reset asserts at once, releases two edges after nrst rises
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstPipe <= lpr_pkg::SYNC_IDLE;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstSync = rstPipe[1];

	// overvoltage comparator output is asynchronous, so two flops
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			ovMeta <= 1'b0;
			ovSync <= 1'b0;
		end else begin
			ovMeta <= overvoltage;
			ovSync <= ovMeta;
		end
	end

	// delay decoding
	assign pressed = !pushbutton_in_n;
	assign pressCycles = lpr_pkg::CNT_W'(PRESS_STEPS) * STEP_CYCLES;
	assign shortCycles = pressCycles / lpr_pkg::CNT_W'(lpr_pkg::TEST_DIVIDE);
	assign tmrBus.restart = (next_state != state);
	assign tmrBus.limit = (state == lpr_pkg::ST_ENTRY) ? ENTRY_CYCLES :
		(state == lpr_pkg::ST_PULSE) ? PULSE_CYCLES :
		testMode ? shortCycles : pressCycles;

	delay_timer u_timer (
		.clk(clk),
		.rstSync(rstSync),
		.tmr(tmrBus.timer)
	);

	// next-state decode
	always_comb begin
		next_state = state;
		unique case (state)
			lpr_pkg::ST_IDLE: begin
				if (pressed) begin
					next_state = lpr_pkg::ST_COUNT;
				end else if (ovSync && !testMode) begin
					next_state = lpr_pkg::ST_ENTRY;
				end
			end
			lpr_pkg::ST_COUNT: begin
				if (!pressed) begin
					next_state = lpr_pkg::ST_IDLE;
				end else if (tmrBus.done) begin
					next_state = FIXED_PULSE ? lpr_pkg::ST_PULSE : lpr_pkg::ST_HELD;
				end
			end
			lpr_pkg::ST_HELD: begin
				if (!pressed) begin
					next_state = lpr_pkg::ST_IDLE;
				end
			end
			lpr_pkg::ST_PULSE: begin
				// button state is ignored for the whole pulse
				if (tmrBus.done) begin
					next_state = lpr_pkg::ST_WAIT;
				end
			end
			lpr_pkg::ST_WAIT: begin
				// a still-held button must not retrigger a second pulse
				if (!pressed && !ovSync) begin
					next_state = lpr_pkg::ST_IDLE;
				end
			end
			lpr_pkg::ST_ENTRY: begin
				if (!ovSync) begin
					next_state = lpr_pkg::ST_IDLE;
				end else if (tmrBus.done) begin
					next_state = FIXED_PULSE ? lpr_pkg::ST_PULSE : lpr_pkg::ST_TESTHELD;
				end
			end
			lpr_pkg::ST_TESTHELD: begin
				if (!ovSync) begin
					next_state = lpr_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = lpr_pkg::ST_IDLE; // unused code recovers to idle
			end
		endcase
	end

	// latch and output decode
	assign next_testMode = testMode || (state == lpr_pkg::ST_ENTRY && ovSync && tmrBus.done);
	assign next_active = (next_state == lpr_pkg::ST_HELD) || (next_state == lpr_pkg::ST_PULSE) ||
		(next_state == lpr_pkg::ST_TESTHELD);
	assign next_level = ACTIVE_HIGH ? next_active : !next_active;

	// sequencer registers; only power-on clears the test latch
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			state <= lpr_pkg::ST_IDLE;
			testMode <= 1'b0;
			resetActive <= 1'b0;
		end else begin
			state <= next_state;
			testMode <= next_testMode;
			resetActive <= next_active;
		end
	end

	// pins straight from flops; open drain only ever pulls low
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			rstOut <= OPEN_DRAIN ? 1'b0 : !ACTIVE_HIGH;
			rstOeN <= OPEN_DRAIN ? !ACTIVE_HIGH : 1'b0;
			testModeActive <= 1'b0;
		end else begin
			rstOut <= OPEN_DRAIN ? 1'b0 : next_level;
			rstOeN <= OPEN_DRAIN ? next_level : 1'b0;
			testModeActive <= next_testMode;
		end
	end

	// helper counters watched only by the checks below
	logic [lpr_pkg::CNT_W-1:0] lowRun; // consecutive pressed cycles
	logic [lpr_pkg::CNT_W-1:0] activeRun; // cycles of the current assertion
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			lowRun <= '0;
			activeRun <= '0;
		end else begin
			lowRun <= pressed ? lowRun + lpr_pkg::CNT_ONE : '0;
			activeRun <= resetActive ? activeRun + lpr_pkg::CNT_ONE : '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync);

	property p_fullPress;
		$rose(resetActive) && $past(state) == lpr_pkg::ST_COUNT && !testMode |-> lowRun >= pressCycles;
	endproperty
	a_fullPress: assert property (p_fullPress) else $error("reset before full press delay");

	property p_shortPress;
		state == lpr_pkg::ST_COUNT && !pressed |=> state == lpr_pkg::ST_IDLE ##1 !resetActive;
	endproperty
	a_shortPress: assert property (p_shortPress) else $error("short press produced reset");

	property p_release;
		!FIXED_PULSE && state == lpr_pkg::ST_HELD && !pressed |=> !resetActive;
	endproperty
	a_release: assert property (p_release) else $error("reset kept after release");

	property p_pulseLen;
		FIXED_PULSE && $fell(resetActive) |-> activeRun == PULSE_CYCLES;
	endproperty
	a_pulseLen: assert property (p_pulseLen) else $error("fixed pulse length wrong");

	property p_pinLevel;
		OPEN_DRAIN ? (rstOut == 1'b0 && rstOeN == (ACTIVE_HIGH ? resetActive : !resetActive))
			: (rstOeN == 1'b0 && rstOut == (ACTIVE_HIGH ? resetActive : !resetActive));
	endproperty
	a_pinLevel: assert property (p_pinLevel) else $error("pin does not match assertion");

	property p_entryStart;
		state == lpr_pkg::ST_IDLE && ovSync && !pressed && !testMode |=> state == lpr_pkg::ST_ENTRY;
	endproperty
	a_entryStart: assert property (p_entryStart) else $error("entry delay not started");

	property p_entryFeedback;
		$rose(testMode) |-> resetActive && $past(state, 1) == lpr_pkg::ST_ENTRY;
	endproperty
	a_entryFeedback: assert property (p_entryFeedback) else $error("no feedback on test entry");

	property p_testPress;
		$rose(resetActive) && $past(state) == lpr_pkg::ST_COUNT && testMode
			|-> lowRun >= shortCycles && lowRun <= shortCycles + lpr_pkg::CNT_ONE;
	endproperty
	a_testPress: assert property (p_testPress) else $error("test press delay wrong");

	property p_testSticky;
		testMode |=> testMode && testModeActive;
	endproperty
	a_testSticky: assert property (p_testSticky) else $error("test mode left without power cycle");

	c_longPress: cover property ($rose(resetActive) && !testMode && $past(state) == lpr_pkg::ST_COUNT);
	c_shortPress: cover property (state == lpr_pkg::ST_COUNT && !pressed);
	c_testEntry: cover property ($rose(testMode));
	c_testPress: cover property ($rose(resetActive) && testMode && $past(state) == lpr_pkg::ST_COUNT);
endmodule : long_press_reset_generator
`default_nettype wire

// ===== hw/lpr_pkg.sv
// constants, states and timing figures for the long-press reset generator
package lpr_pkg;
	localparam int unsigned CNT_W = 32; // width of every delay counter
	localparam int unsigned CLK_HZ = 50_000_000; // system clock rate
	localparam int unsigned MS_PER_S = 1000; // milliseconds in a second
	localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S; // cycles in one millisecond
	localparam int unsigned PRESS_STEP_MS = 500; // long_press_delay granularity, 0.5 s
	localparam int unsigned PRESS_STEPS_MIN = 1; // 0.5 s
	localparam int unsigned PRESS_STEPS_MAX = 20; // 10 s
	localparam int unsigned PRESS_STEPS_DEF = 3; // 1.5 s default build
	localparam int unsigned TEST_ENTRY_MS = 42; // test_entry_delay, typical
	localparam int unsigned FIXED_PULSE_MS = 210; // fixed_pulse_time, shorter build option
	localparam int unsigned TEST_DIVIDE = 128; // test_press_delay = long_press_delay / 128
	localparam logic [CNT_W-1:0] STEP_CYCLES = CNT_W'(PRESS_STEP_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] ENTRY_CYCLES = CNT_W'(TEST_ENTRY_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] PULSE_CYCLES = CNT_W'(FIXED_PULSE_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1); // counter step
	localparam logic [1:0] SYNC_IDLE = 2'h0; // synchroniser reset pattern

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, // button released, output inactive
		ST_COUNT = 3'h1, // button held, counting the press delay
		ST_HELD = 3'h2, // output asserted while the button is held
		ST_PULSE = 3'h3, // output asserted for the fixed pulse time
		ST_WAIT = 3'h4, // pulse done, waiting for a quiet input
		ST_ENTRY = 3'h5, // overvoltage seen, counting the entry delay
		ST_TESTHELD = 3'h6 // output asserted while overvoltage stays
	} state_e;
endpackage : lpr_pkg

// ===== tb/button_partner.sv
// push-button switch and processor reset pin seen by the generator
`timescale 1ns/1ps
`default_nettype none
module button_partner (
	input wire logic pressReq,
	input wire logic ovReq,
	input wire logic rstOut,
	input wire logic rstOeN,
	output logic pushbutton_in_n,
	output logic overvoltage,
	output logic cpuResetN
);
	// a closed switch pulls low; an overvoltage source holds the line high
	assign pushbutton_in_n = ovReq | ~pressReq;
	// the detector flag follows the overvoltage source directly; the source is
	// only raised once the supply is up, so power-on never lands in test mode
	assign overvoltage = ovReq;
	// pull-up on the processor pin wins whenever the driver lets go
	assign cpuResetN = rstOeN ? 1'b1 : rstOut;
endmodule : button_partner
`default_nettype wire

// ===== tb/test_long_press_reset_generator.sv
// self-checking bench with a cycle model for the long-press reset generator
`timescale 1ns/1ps
`default_nettype none
module test_long_press_reset_generator;
	localparam int L = 256; // press delay in cycles, one shortened step
	localparam int ENT = 40; // shortened entry delay
	localparam int PUL = 30; // shortened fixed pulse
	localparam int LIMIT = 20000; // hang ceiling, run needs about 2700
	localparam int STEPS = 1; // one press step in both builds
	localparam logic [31:0] STEPC = 32'h100; // shortened step, gives L
	localparam logic [31:0] ENTC = 32'h28; // shortened entry delay, same as ENT
	localparam logic [31:0] PULC = 32'h1E; // shortened fixed pulse, same as PUL
	localparam bit FIX_ON = 1'b1; // second build uses the fixed pulse
	localparam bit HIGH_ON = 1'b1; // second build drives an active-high pin
	localparam bit OD_OFF = 1'b0; // second build is push-pull
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic pressReq = 1'b0;
	logic ovReq = 1'b0;
	wire logic pbN, ovFlag, outA, oeA, outB, oeB, tmA, tmB, pinA, pinB;
	// model state; edges of a transition are skipped, the design may take a cycle or two
	int held = 0, relAge = 99, ovHeld = 0, ovAge = 99, tMode = 0, lc, ex;
	int fw = 0, nFix = 0, expFix = 0, cyc = 0, bad_count = 0, cmp_count = 0;

	always #10 clk = ~clk;

	// button-controlled open-drain active-low build under full test; pulse length unused here
	long_press_reset_generator #(.PRESS_STEPS(STEPS), .STEP_CYCLES(STEPC), .ENTRY_CYCLES(ENTC))
		dut_u (.clk(clk), .nrst(nrst), .pushbutton_in_n(pbN),
		.overvoltage(ovFlag), .rstOut(outA), .rstOeN(oeA), .testModeActive(tmA));
	// fixed-pulse push-pull active-high build fed the same inputs, judged by pulse widths
	long_press_reset_generator #(.PRESS_STEPS(STEPS), .STEP_CYCLES(STEPC), .ENTRY_CYCLES(ENTC),
		.PULSE_CYCLES(PULC), .FIXED_PULSE(FIX_ON), .ACTIVE_HIGH(HIGH_ON), .OPEN_DRAIN(OD_OFF))
		dutFixed (.clk(clk), .nrst(nrst),
		.pushbutton_in_n(pbN), .overvoltage(ovFlag), .rstOut(outB), .rstOeN(oeB), .testModeActive(tmB));
	button_partner partnerA (.pressReq(pressReq), .ovReq(ovReq), .rstOut(outA), .rstOeN(oeA),
		.pushbutton_in_n(pbN), .overvoltage(ovFlag), .cpuResetN(pinA));
	button_partner partnerB (.pressReq(pressReq), .ovReq(ovReq), .rstOut(outB), .rstOeN(oeB),
		.pushbutton_in_n(), .overvoltage(), .cpuResetN(pinB));

	// single-bit compare
	task automatic check_bit(input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : check_bit

	// count compare
	task automatic check_num(input int e, input int g);
		cmp_count++;
		if (g != e) begin
			bad_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : check_num

	// verdict and end of run
	task automatic close_out();
		$display("compares=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	// press for dur edges, then stay released for gap edges
	task automatic press(input int dur, input int gap);
		@(posedge clk);
		#1 pressReq = 1'b1;
		repeat (dur) @(posedge clk);
		#1 pressReq = 1'b0;
		if (dur >= (tMode ? L / 128 : L) + 3) expFix++;
		repeat (gap) @(posedge clk);
	endtask : press

	// overvoltage for dur edges
	task automatic ov_pulse(input int dur, input int gap);
		@(posedge clk);
		#1 ovReq = 1'b1;
		repeat (dur) @(posedge clk);
		#1 ovReq = 1'b0;
		if (dur >= ENT + 6) expFix++;
		repeat (gap) @(posedge clk);
	endtask : ov_pulse

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			bad_count++;
			close_out();
		end
	end

	// model: count edges held, ages since release, latch test mode
	always @(posedge clk) begin
		if (!nrst) begin
			held = 0;
			ovHeld = 0;
			tMode = 0; // power cycle clears the latch
			relAge = 99;
			ovAge = 99;
		end else begin
			relAge = (pbN && held > 0) ? 0 : relAge + 1;
			held = pbN ? 0 : held + 1;
			ovAge = (!ovFlag && ovHeld > 0) ? 0 : ovAge + 1;
			ovHeld = ovFlag ? ovHeld + 1 : 0;
			if (ovHeld == ENT + 3) tMode = 1;
		end
	end

	// compare in mid-cycle, where everything has settled
	always @(negedge clk) begin
		lc = tMode ? L / 128 : L;
		ex = 0;
		if (held >= lc + 3) ex = 1;
		else if (held >= lc - 1) ex = 2;
		if (ovHeld >= ENT + 6) ex = 1;
		else if (ovHeld >= ENT - 1) ex = 2;
		if (relAge < 3 || ovAge < 4) ex = 2;
		if (nrst && ex != 2) check_bit(ex == 1 ? 1'b0 : 1'b1, pinA);
		if (nrst && (ovHeld < ENT - 1 || ovHeld > ENT + 5)) begin
			check_bit(tMode[0], tmA);
			check_bit(tMode[0], tmB);
		end
		// a push-pull pin never lets go of the line
		if (nrst) check_bit(1'b0, oeB);
		// active-high build: count cycles with the pin high
		if (pinB === 1'b1) begin
			fw++;
		end else if (fw > 0) begin
			check_num(PUL, fw);
			fw = 0;
			nFix++;
		end
	end

	// main sequence
	initial begin
		void'($urandom(32'h5E38B763));
		repeat (10) @(posedge clk);
		#1 check_bit(1'b1, pinA);
		check_bit(1'b0, pinB);
		check_bit(1'b0, tmA);
		check_bit(1'b0, tmB);
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 5; i++) press($urandom_range(L - 2, 1), 8);
		for (int i = 0; i < 3; i++) press($urandom_range(L + 20, L + 3), 40);
		press(L + 60, 40);
		ov_pulse(ENT - 10, 20);
		ov_pulse(ENT + 20, 40);
		press(1, 8);
		for (int i = 0; i < 4; i++) press($urandom_range(12, 6), 40);
		#1 nrst = 1'b0;
		repeat (3) @(posedge clk);
		#1 check_bit(1'b0, tmA);
		check_bit(1'b1, pinA);
		check_bit(1'b0, pinB);
		check_bit(1'b0, tmB);
		nrst = 1'b1;
		repeat (5) @(posedge clk);
		press(L + 5, 40);
		check_num(expFix, nFix);
		close_out();
	end
endmodule : test_long_press_reset_generator
`default_nettype wire
